// ---- src/ser_cond_event.sv ----
// One status register with condition, event and enable parts.
// Conditions are live levels from the same clock domain.
`timescale 1ns/100ps
`include "ser_regs.svh"

module ser_cond_event
	import ser_pkg::*;
#(
	parameter logic [15:0] USED = 16'h0000
) (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_ce,
	input wire logic [15:0] i_cond,
	input wire logic i_rd_clr,
	input wire logic i_en_wr,
	input wire logic [15:0] i_en_data,
	output logic [15:0] o_cond,
	output logic [15:0] o_evt,
	output logic [15:0] o_en,
	output logic o_sum
);
	ser_ce_st_t st_r;
	ser_ce_st_t st_nxt;
	logic [15:0] rise;

	always_comb begin
		st_nxt = st_r;
		rise = i_cond & ~st_r.cond & USED;
		st_nxt.cond = i_cond & USED;
		// Rising condition lands even in the cycle the event is read
		st_nxt.evt = (i_rd_clr ? 16'h0000 : st_r.evt) | rise;
		if (i_en_wr) begin
			st_nxt.en = i_en_data & USED;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			st_r <= '{cond: 16'h0000, evt: 16'h0000, en: `SER_EN_RST};
		end else if (i_ce) begin
			st_r <= st_nxt;
		end
	end

	assign o_cond = st_r.cond;
	assign o_evt = st_r.evt;
	assign o_en = st_r.en;
	assign o_sum = |(st_r.evt & st_r.en);

endmodule

// ---- src/ser_opc_tracker.sv ----
// Operation complete tracker: counts commands still executing and
// fires once every command received before the request is done.
// Start and done strobes come from the same clock domain.
`timescale 1ns/100ps
`include "ser_regs.svh"

module ser_opc_tracker
	import ser_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_ce,
	input wire logic i_opc_cmd,
	input wire logic i_exec_start,
	input wire logic i_exec_done,
	output logic o_opc_pulse
);
	localparam int CW = `SER_OPC_CNT_W;

	ser_opc_st_t st_r;
	ser_opc_st_t st_nxt;
	logic dn;
	logic [CW-1:0] left;
	logic [CW-1:0] ahead_n;
	logic watch;

	always_comb begin
		st_nxt = st_r;
		// A stray done with nothing running is ignored, not wrapped
		dn = i_exec_done && (st_r.outstanding != '0);
		left = st_r.outstanding - {{(CW-1){1'b0}}, dn};
		st_nxt.outstanding = left + {{(CW-1){1'b0}}, i_exec_start};
		ahead_n = left;
		watch = i_opc_cmd;
		case (st_r.fsm)
			SER_OPC_IDLE: begin
				ahead_n = left;
			end
			SER_OPC_ARMED: begin
				// A newer request covers everything the older one did
				ahead_n = i_opc_cmd ? left : st_r.ahead - {{(CW-1){1'b0}}, dn};
				watch = 1'b1;
			end
			default: begin
				watch = 1'b0;
			end
		endcase
		st_nxt.done = watch && (ahead_n == '0);
		st_nxt.ahead = ahead_n;
		st_nxt.fsm = (watch && ahead_n != '0) ? SER_OPC_ARMED : SER_OPC_IDLE;
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			st_r <= '{fsm: SER_OPC_IDLE, outstanding: '0, ahead: '0, done: 1'b0};
		end else if (i_ce) begin
			st_r <= st_nxt;
		end
	end

	assign o_opc_pulse = st_r.done;

endmodule

// ---- src/ser_pkg.sv ----
// Types shared by the status event register bank.
// Needs ser_regs.svh on the include path.
`include "ser_regs.svh"

package ser_pkg;

	typedef enum logic [3:0] {
		SER_CMD_NONE = 4'h0,
		SER_CMD_RD_ESR = 4'h1,
		SER_CMD_WR_ESE = 4'h2,
		SER_CMD_RD_ESE = 4'h3,
		SER_CMD_RD_OPER_COND = 4'h4,
		SER_CMD_RD_OPER_EVT = 4'h5,
		SER_CMD_WR_OPER_EN = 4'h6,
		SER_CMD_RD_OPER_EN = 4'h7,
		SER_CMD_RD_QUES_COND = 4'h8,
		SER_CMD_RD_QUES_EVT = 4'h9,
		SER_CMD_WR_QUES_EN = 4'hA,
		SER_CMD_RD_QUES_EN = 4'hB,
		SER_CMD_CLEAR = 4'hC
	} ser_cmd_code_t;

	typedef struct packed {
		logic valid;
		ser_cmd_code_t code;
		logic [15:0] data;
	} ser_cmd_t;

	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} ser_rsp_t;

	typedef struct packed {
		logic valid;
		logic [15:0] code;
	} ser_log_t;

	typedef struct packed {
		logic read_no_query;
		logic unread_then_cmd;
		logic dev_err;
		logic exec_err;
		logic cmd_err;
	} ser_err_evt_t;

	typedef struct packed {
		logic pwr;
		logic freq;
		logic limit;
	} ser_ques_in_t;

	typedef struct packed {
		logic oper;
		logic esb;
		logic ques;
	} ser_sum_t;

	typedef struct packed {
		logic [15:0] cond;
		logic [15:0] evt;
		logic [15:0] en;
	} ser_ce_st_t;

	typedef enum logic [1:0] {
		SER_OPC_IDLE = 2'b01,
		SER_OPC_ARMED = 2'b10
	} ser_opc_fsm_t;

	typedef struct packed {
		ser_opc_fsm_t fsm;
		logic [`SER_OPC_CNT_W-1:0] outstanding;
		logic [`SER_OPC_CNT_W-1:0] ahead;
		logic done;
	} ser_opc_st_t;

	typedef struct packed {
		logic [7:0] event_status;
		logic [7:0] event_status_enable;
		ser_rsp_t rsp;
		ser_log_t log;
		ser_sum_t sum;
	} ser_main_st_t;

endpackage

// ---- src/ser_regs.svh ----
// Constants of the status event register bank: bit positions,
// masks of implemented bits, reset values and error code ranges.
// Definitions only; included by the package and every module except the host model.
`ifndef SER_REGS_SVH
`define SER_REGS_SVH

// ----------------------------------------------------------------
// Event status bit positions
// ----------------------------------------------------------------
`define SER_ESR_OPC 0
`define SER_ESR_QYE 2
`define SER_ESR_DDE 3
`define SER_ESR_EXE 4
`define SER_ESR_CME 5
`define SER_ESR_PON 7
`define SER_ESR_USED 8'hBD
`define SER_ESR_RST 8'h80
`define SER_ESE_RST 8'h00

// ----------------------------------------------------------------
// Operation and questionable registers
// ----------------------------------------------------------------
`define SER_OPER_USED 16'h0000
`define SER_QUES_USED 16'h0228
`define SER_QUES_PWR 3
`define SER_QUES_FREQ 5
`define SER_QUES_LIM 9
`define SER_EN_RST 16'h0000

// ----------------------------------------------------------------
// Error code ranges, two's complement, bounds inclusive
// ----------------------------------------------------------------
`define SER_DDE_LO 16'hFE71
`define SER_DDE_HI 16'hFED4
`define SER_EXE_LO 16'hFED4
`define SER_EXE_HI 16'hFF38
`define SER_CME_LO 16'hFF38
`define SER_CME_HI 16'hFF9C

// Width of the outstanding command counter
`define SER_OPC_CNT_W 8

`endif

// ---- src/ser_status_regs.sv ----
// Status event register bank: event status and its enable,
// operation and questionable registers, status byte summaries.
// Commands arrive already parsed on the same clock; event strobes
// and condition levels come from logic on that clock.
`timescale 1ns/100ps
`include "ser_regs.svh"

module ser_status_regs
	import ser_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_ce,
	input wire ser_cmd_t i_cmd,
	input wire logic i_opc_cmd,
	input wire logic i_exec_start,
	input wire logic i_exec_done,
	input wire ser_err_evt_t i_err_evt,
	input wire logic [15:0] i_dev_code,
	input wire logic [15:0] i_exec_code,
	input wire logic [15:0] i_cmd_err_code,
	input wire logic [15:0] i_oper_cond,
	input wire ser_ques_in_t i_ques,
	output ser_rsp_t o_rsp,
	output ser_log_t o_err_log,
	output ser_sum_t o_stb_sum
);

	// ----------------------------------------------------------------
	// Decoding helpers
	// ----------------------------------------------------------------
	function automatic logic cmd_hit(input ser_cmd_t c, input ser_cmd_code_t k);
		cmd_hit = c.valid && (c.code == k);
	endfunction

	function automatic logic is_query(input ser_cmd_code_t k);
		case (k)
			SER_CMD_RD_ESR, SER_CMD_RD_ESE,
			SER_CMD_RD_OPER_COND, SER_CMD_RD_OPER_EVT, SER_CMD_RD_OPER_EN,
			SER_CMD_RD_QUES_COND, SER_CMD_RD_QUES_EVT, SER_CMD_RD_QUES_EN: begin
				is_query = 1'b1;
			end
			default: begin
				is_query = 1'b0;
			end
		endcase
	endfunction

	// Out of range codes fall back to the class's generic code
	function automatic logic [15:0] fix_code(
		input logic [15:0] code,
		input logic [15:0] lo,
		input logic [15:0] hi,
		input logic pos_ok
	);
		logic in_rng;
		logic pos;
		in_rng = ($signed(code) >= $signed(lo)) && ($signed(code) <= $signed(hi));
		pos = pos_ok && ($signed(code) > $signed(16'h0000));
		fix_code = (in_rng || pos) ? code : hi;
	endfunction

	// ----------------------------------------------------------------
	// State and submodule wiring
	// ----------------------------------------------------------------
	ser_main_st_t st_r;
	ser_main_st_t st_nxt;
	logic opc_pulse;
	logic [7:0] esr_set;
	logic [7:0] esr_base;
	logic [15:0] rd_data;
	logic [15:0] ques_cond_in;
	logic [15:0] oper_cond;
	logic [15:0] oper_evt;
	logic [15:0] oper_en;
	logic oper_sum;
	logic [15:0] ques_cond;
	logic [15:0] ques_evt;
	logic [15:0] ques_en;
	logic ques_sum;
	logic clr_all;

	assign clr_all = cmd_hit(i_cmd, SER_CMD_CLEAR);

	ser_opc_tracker u_opc (
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_ce(i_ce),
		.i_opc_cmd(i_opc_cmd),
		.i_exec_start(i_exec_start),
		.i_exec_done(i_exec_done),
		.o_opc_pulse(opc_pulse)
	);

	// Every operation bit is unused, so this part stays at zero
	ser_cond_event #(.USED(`SER_OPER_USED)) u_oper (
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_ce(i_ce),
		.i_cond(i_oper_cond),
		.i_rd_clr(cmd_hit(i_cmd, SER_CMD_RD_OPER_EVT) || clr_all),
		.i_en_wr(cmd_hit(i_cmd, SER_CMD_WR_OPER_EN)),
		.i_en_data(i_cmd.data),
		.o_cond(oper_cond),
		.o_evt(oper_evt),
		.o_en(oper_en),
		.o_sum(oper_sum)
	);

	always_comb begin
		ques_cond_in = 16'h0000;
		ques_cond_in[`SER_QUES_PWR] = i_ques.pwr;
		ques_cond_in[`SER_QUES_FREQ] = i_ques.freq;
		ques_cond_in[`SER_QUES_LIM] = i_ques.limit;
	end

	ser_cond_event #(.USED(`SER_QUES_USED)) u_ques (
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_ce(i_ce),
		.i_cond(ques_cond_in),
		.i_rd_clr(cmd_hit(i_cmd, SER_CMD_RD_QUES_EVT) || clr_all),
		.i_en_wr(cmd_hit(i_cmd, SER_CMD_WR_QUES_EN)),
		.i_en_data(i_cmd.data),
		.o_cond(ques_cond),
		.o_evt(ques_evt),
		.o_en(ques_en),
		.o_sum(ques_sum)
	);

	// ----------------------------------------------------------------
	// Query data
	// ----------------------------------------------------------------
	always_comb begin
		case (i_cmd.code)
			SER_CMD_RD_ESR: rd_data = {8'h00, st_r.event_status};
			SER_CMD_RD_ESE: rd_data = {8'h00, st_r.event_status_enable};
			SER_CMD_RD_OPER_COND: rd_data = oper_cond;
			SER_CMD_RD_OPER_EVT: rd_data = oper_evt;
			SER_CMD_RD_OPER_EN: rd_data = oper_en;
			SER_CMD_RD_QUES_COND: rd_data = ques_cond;
			SER_CMD_RD_QUES_EVT: rd_data = ques_evt;
			SER_CMD_RD_QUES_EN: rd_data = ques_en;
			default: rd_data = 16'h0000;
		endcase
	end

	// ----------------------------------------------------------------
	// Event status, enable, error log and summaries
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		esr_set = 8'h00;
		esr_set[`SER_ESR_OPC] = opc_pulse;
		esr_set[`SER_ESR_QYE] = i_err_evt.read_no_query | i_err_evt.unread_then_cmd;
		esr_set[`SER_ESR_DDE] = i_err_evt.dev_err;
		esr_set[`SER_ESR_EXE] = i_err_evt.exec_err;
		esr_set[`SER_ESR_CME] = i_err_evt.cmd_err;
		// Reply carries the old value; new events survive the clear
		esr_base = (cmd_hit(i_cmd, SER_CMD_RD_ESR) || clr_all) ? 8'h00 : st_r.event_status;
		st_nxt.event_status = (esr_base | esr_set) & `SER_ESR_USED;
		if (cmd_hit(i_cmd, SER_CMD_WR_ESE)) begin
			st_nxt.event_status_enable = i_cmd.data[7:0] & `SER_ESR_USED;
		end
		st_nxt.rsp.valid = i_cmd.valid && is_query(i_cmd.code);
		st_nxt.rsp.data = st_nxt.rsp.valid ? rd_data : st_r.rsp.data;
		// One log entry per cycle; a lower class in the same cycle is dropped
		st_nxt.log.valid = i_err_evt.cmd_err || i_err_evt.exec_err || i_err_evt.dev_err;
		if (i_err_evt.cmd_err) begin
			st_nxt.log.code = fix_code(i_cmd_err_code, `SER_CME_LO, `SER_CME_HI, 1'b0);
		end else if (i_err_evt.exec_err) begin
			st_nxt.log.code = fix_code(i_exec_code, `SER_EXE_LO, `SER_EXE_HI, 1'b0);
		end else if (i_err_evt.dev_err) begin
			st_nxt.log.code = fix_code(i_dev_code, `SER_DDE_LO, `SER_DDE_HI, 1'b1);
		end
		st_nxt.sum.esb = |(st_nxt.event_status & st_nxt.event_status_enable);
		st_nxt.sum.ques = ques_sum;
		st_nxt.sum.oper = oper_sum;
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			st_r <= '{
				event_status: `SER_ESR_RST,
				event_status_enable: `SER_ESE_RST,
				rsp: '{valid: 1'b0, data: 16'h0000},
				log: '{valid: 1'b0, code: 16'h0000},
				sum: '{oper: 1'b0, esb: 1'b0, ques: 1'b0}
			};
		end else if (i_ce) begin
			st_r <= st_nxt;
		end
	end

	assign o_rsp = st_r.rsp;
	assign o_err_log = st_r.log;
	assign o_stb_sum = st_r.sum;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rstn);

	sequence s_ese_write;
		i_ce && cmd_hit(i_cmd, SER_CMD_WR_ESE);
	endsequence

	sequence s_ese_read;
		i_ce && cmd_hit(i_cmd, SER_CMD_RD_ESE) && !cmd_hit(i_cmd, SER_CMD_WR_ESE);
	endsequence

	sequence s_esr_read;
		i_ce && cmd_hit(i_cmd, SER_CMD_RD_ESR);
	endsequence

	sequence s_clear_all;
		i_ce && clr_all;
	endsequence

	chk_opc_sets_bit: assert property (
		i_ce && i_opc_cmd && !i_exec_start && !i_exec_done && u_opc.st_r.outstanding == '0
		##1 i_ce |=> st_r.event_status[`SER_ESR_OPC])
		else $error("operation complete not set with nothing pending");

	chk_opc_waits: assert property (
		u_opc.st_r.fsm == SER_OPC_ARMED && !i_exec_done && !i_opc_cmd |-> !u_opc.st_nxt.done)
		else $error("operation complete fired while commands pending");

	chk_query_err: assert property (
		i_ce && (i_err_evt.read_no_query || i_err_evt.unread_then_cmd) |=> st_r.event_status[`SER_ESR_QYE])
		else $error("query error bit not set");

	chk_dev_err_log: assert property (
		i_ce && i_err_evt.dev_err && !i_err_evt.cmd_err && !i_err_evt.exec_err |=>
		st_r.event_status[`SER_ESR_DDE] && o_err_log.valid &&
		(($signed(o_err_log.code) >= $signed(`SER_DDE_LO) && $signed(o_err_log.code) <= $signed(`SER_DDE_HI))
		|| $signed(o_err_log.code) > $signed(16'h0000)))
		else $error("device error not flagged or code out of range");

	chk_exec_err_log: assert property (
		i_ce && i_err_evt.exec_err && !i_err_evt.cmd_err |=>
		st_r.event_status[`SER_ESR_EXE] && o_err_log.valid &&
		$signed(o_err_log.code) >= $signed(`SER_EXE_LO) && $signed(o_err_log.code) <= $signed(`SER_EXE_HI))
		else $error("execution error not flagged or code out of range");

	chk_cmd_err_log: assert property (
		i_ce && i_err_evt.cmd_err |=>
		st_r.event_status[`SER_ESR_CME] && o_err_log.valid &&
		$signed(o_err_log.code) >= $signed(`SER_CME_LO) && $signed(o_err_log.code) <= $signed(`SER_CME_HI))
		else $error("command error not flagged or code out of range");

	chk_power_on: assert property (
		$rose(i_rstn) |-> st_r.event_status[`SER_ESR_PON] && st_r.event_status[6:0] == 7'h00)
		else $error("power on bit missing after reset");

	chk_esr_read_clear: assert property (
		s_esr_read |=> o_rsp.valid && o_rsp.data == {8'h00, $past(st_r.event_status)} &&
		st_r.event_status == $past(esr_set & `SER_ESR_USED))
		else $error("event status read did not return and clear");

	chk_ese_readback: assert property (
		s_ese_write ##1 !(i_ce && i_cmd.valid) ##1 s_ese_read |=> o_rsp.valid &&
		o_rsp.data == {8'h00, $past(i_cmd.data[7:0], 3) & `SER_ESR_USED})
		else $error("enable mask readback mismatch");

	chk_oper_zero: assert property (
		oper_cond == 16'h0000 && oper_evt == 16'h0000 && oper_en == 16'h0000 && !oper_sum)
		else $error("operation register shows an unused bit");

	chk_ques_hold: assert property (
		i_ce && !cmd_hit(i_cmd, SER_CMD_RD_QUES_EVT) && !clr_all |=>
		(ques_evt & $past(ques_evt)) == $past(ques_evt))
		else $error("questionable event lost before read");

	chk_ques_pwr_freq: assert property (
		i_ce && (i_ques.pwr && !ques_cond[`SER_QUES_PWR] || i_ques.freq && !ques_cond[`SER_QUES_FREQ]) |=>
		(ques_evt[`SER_QUES_PWR] || !$past(i_ques.pwr && !ques_cond[`SER_QUES_PWR])) &&
		(ques_evt[`SER_QUES_FREQ] || !$past(i_ques.freq && !ques_cond[`SER_QUES_FREQ])))
		else $error("power or frequency event not latched");

	chk_ques_limit: assert property (
		i_ce && i_ques.limit && !ques_cond[`SER_QUES_LIM] |=> ques_evt[`SER_QUES_LIM] && ques_cond[`SER_QUES_LIM])
		else $error("limit event not latched");

	chk_ques_unused: assert property (
		((ques_cond | ques_evt | ques_en) & ~`SER_QUES_USED) == 16'h0000 &&
		(st_r.event_status & ~`SER_ESR_USED) == 8'h00 && (st_r.event_status_enable & ~`SER_ESR_USED) == 8'h00)
		else $error("unused status bit set");

	chk_esb_sum: assert property (
		o_stb_sum.esb == |(st_r.event_status & st_r.event_status_enable))
		else $error("event summary disagrees with enabled events");

	chk_ques_oper_sum: assert property (
		i_ce |=> o_stb_sum.ques == $past(|(ques_evt & ques_en)) && o_stb_sum.oper == $past(oper_sum))
		else $error("register summary bit wrong");

	chk_read_keeps_new: assert property (
		s_esr_read and i_err_evt.cmd_err |=> st_r.event_status[`SER_ESR_CME])
		else $error("event arriving during read was lost");

	chk_ese_write: assert property (
		s_ese_write |=> st_r.event_status_enable == ($past(i_cmd.data[7:0]) & `SER_ESR_USED))
		else $error("enable mask write not stored");

	chk_clear_all: assert property (
		s_clear_all |=> st_r.event_status == $past(esr_set & `SER_ESR_USED) &&
		(ques_evt & ~$past(ques_cond_in)) == 16'h0000)
		else $error("clear left an old event standing");

	chk_rsp_idle: assert property (
		i_ce && !(i_cmd.valid && is_query(i_cmd.code)) |=> !o_rsp.valid)
		else $error("reply without a query");

	chk_log_idle: assert property (
		i_ce && !(i_err_evt.dev_err || i_err_evt.exec_err || i_err_evt.cmd_err) |=> !o_err_log.valid)
		else $error("error logged without an error event");

	chk_ques_cond_live: assert property (
		i_ce |=> ques_cond == ($past(ques_cond_in) & `SER_QUES_USED))
		else $error("questionable condition does not follow inputs");

endmodule

// ---- verification/ser_host_model.sv ----
// Host controller model: issues parsed status commands, collects replies.
// Assumes a reply is registered on the same edge that takes the command.
`timescale 1ns/100ps

module ser_host_model
	import ser_pkg::*;
(
	input wire logic i_ref_clk,
	input wire ser_rsp_t i_rsp,
	output ser_cmd_t o_cmd
);
	// ----------------------------------------------------------------
	// Command issue
	// ----------------------------------------------------------------
	initial o_cmd = '0;

	// Released data is inverted so a stale word never passes for a fresh one
	task automatic send(input ser_cmd_code_t c, input logic [15:0] d);
		@(posedge i_ref_clk);
		o_cmd <= '{valid: 1'b1, code: c, data: d};
		@(posedge i_ref_clk);
		o_cmd <= '{valid: 1'b0, code: SER_CMD_NONE, data: ~d};
	endtask

	task automatic query(input ser_cmd_code_t c, output logic [15:0] d, output logic ok);
		send(c, 16'h0000);
		@(negedge i_ref_clk);
		ok = i_rsp.valid;
		d = i_rsp.data;
	endtask
endmodule

// ---- verification/test_ser_status_regs.sv ----
// Self-checking bench for the status event register bank.
// Assumes the design package and ser_status_regs are compiled first.
`timescale 1ns/100ps
`include "ser_regs.svh"

module test_ser_status_regs
	import ser_pkg::*;
;
	logic i_ref_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic i_ce = 1'b1;
	ser_cmd_t cmd;
	logic opc = 1'b0;
	logic xs = 1'b0;
	logic xd = 1'b0;
	ser_err_evt_t err = '0;
	logic [15:0] ecode = 16'h0000;
	logic [15:0] oper = 16'h0000;
	ser_ques_in_t ques = '0;
	ser_rsp_t rsp;
	ser_log_t log_o;
	ser_sum_t sum;
	int num_errors = 0;
	int n_tests = 0;
	ser_err_evt_t evt_tab [6] = '{5'h01, 5'h02, 5'h04, 5'h04, 5'h10, 5'h08};
	logic [15:0] cin_tab [6] = '{16'hFF90, 16'hFF00, 16'h0005, 16'hFF90, 16'h0000, 16'h0000};
	logic [15:0] cout_tab [6] = '{16'hFF90, 16'hFF00, 16'h0005, 16'hFED4, 16'h0000, 16'h0000};
	logic [15:0] esr_tab [6] = '{16'h0020, 16'h0010, 16'h0008, 16'h0008, 16'h0004, 16'h0004};
	logic [15:0] qb_tab [3] = '{16'h0200, 16'h0020, 16'h0008};

	always #50 i_ref_clk = ~i_ref_clk;

	ser_host_model i_host (
		.i_ref_clk(i_ref_clk),
		.i_rsp(rsp),
		.o_cmd(cmd)
	);

	ser_status_regs i_dut (
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_ce(i_ce),
		.i_cmd(cmd),
		.i_opc_cmd(opc),
		.i_exec_start(xs),
		.i_exec_done(xd),
		.i_err_evt(err),
		.i_dev_code(ecode),
		.i_exec_code(ecode),
		.i_cmd_err_code(ecode),
		.i_oper_cond(oper),
		.i_ques(ques),
		.o_rsp(rsp),
		.o_err_log(log_o),
		.o_stb_sum(sum)
	);

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rd(input ser_cmd_code_t c, input logic [15:0] e);
		logic [15:0] d;
		logic ok;
		i_host.query(c, d, ok);
		chk({15'h0000, ok}, 16'h0001);
		chk(d, e);
	endtask

	// One error strobe; returns at the negedge where the log entry stands
	task automatic fire(input ser_err_evt_t e, input logic [15:0] c);
		@(posedge i_ref_clk);
		err <= e;
		ecode <= c;
		@(posedge i_ref_clk);
		err <= '0;
		@(negedge i_ref_clk);
	endtask

	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Watchdog: the sequence needs well under a thousand cycles
	// ----------------------------------------------------------------
	initial begin
		#(100 * 5000);
		num_errors++;
		test_done();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [15:0] d;
		logic ok;
		repeat (16) @(posedge i_ref_clk);
		i_rstn <= 1'b1;
		rd(SER_CMD_RD_ESR, {8'h00, `SER_ESR_RST});
		rd(SER_CMD_RD_ESR, 16'h0000);
		i_host.send(SER_CMD_WR_ESE, 16'h00FF);
		rd(SER_CMD_RD_ESE, 16'h00BD);
		for (int k = 0; k < 6; k++) begin
			fire(evt_tab[k], cin_tab[k]);
			chk({15'h0000, log_o.valid}, {15'h0000, k < 4});
			if (k < 4) chk(log_o.code, cout_tab[k]);
			@(negedge i_ref_clk);
			chk({15'h0000, sum.esb}, 16'h0001);
			rd(SER_CMD_RD_ESR, esr_tab[k]);
		end
		@(negedge i_ref_clk);
		chk({15'h0000, sum.esb}, 16'h0000);
		// Masked event must stay out of the summary
		i_host.send(SER_CMD_WR_ESE, 16'h0000);
		fire(5'h01, 16'hFF90);
		repeat (2) @(negedge i_ref_clk);
		chk({15'h0000, sum.esb}, 16'h0000);
		i_host.send(SER_CMD_CLEAR, 16'h0000);
		rd(SER_CMD_RD_ESR, 16'h0000);
		// Event landing on the read edge must survive the clear
		fork
			i_host.send(SER_CMD_RD_ESR, 16'h0000);
			fire(5'h01, 16'hFF90);
		join
		rd(SER_CMD_RD_ESR, 16'h0020);
		// Completion waits for the command already executing
		@(posedge i_ref_clk);
		xs <= 1'b1;
		@(posedge i_ref_clk);
		xs <= 1'b0;
		opc <= 1'b1;
		@(posedge i_ref_clk);
		opc <= 1'b0;
		repeat (4) @(posedge i_ref_clk);
		rd(SER_CMD_RD_ESR, 16'h0000);
		@(posedge i_ref_clk);
		xd <= 1'b1;
		@(posedge i_ref_clk);
		xd <= 1'b0;
		repeat (3) @(posedge i_ref_clk);
		rd(SER_CMD_RD_ESR, 16'h0001);
		// Nothing pending: completion follows the request directly
		@(posedge i_ref_clk);
		opc <= 1'b1;
		@(posedge i_ref_clk);
		opc <= 1'b0;
		rd(SER_CMD_RD_ESR, 16'h0001);
		// Questionable bits one at a time, then summary
		i_host.send(SER_CMD_WR_QUES_EN, 16'hFFFF);
		rd(SER_CMD_RD_QUES_EN, `SER_QUES_USED);
		for (int k = 0; k < 3; k++) begin
			@(posedge i_ref_clk);
			ques <= ser_ques_in_t'(3'b001 << k);
			repeat (3) @(posedge i_ref_clk);
			rd(SER_CMD_RD_QUES_COND, qb_tab[k]);
			chk({15'h0000, sum.ques}, 16'h0001);
			rd(SER_CMD_RD_QUES_EVT, qb_tab[k]);
			rd(SER_CMD_RD_QUES_EVT, 16'h0000);
			@(negedge i_ref_clk);
			chk({15'h0000, sum.ques}, 16'h0000);
			rd(SER_CMD_RD_QUES_COND, qb_tab[k]);
		end
		@(posedge i_ref_clk);
		ques <= '0;
		// Operation register has no implemented bits
		oper <= 16'hFFFF;
		i_host.send(SER_CMD_WR_OPER_EN, 16'hFFFF);
		rd(SER_CMD_RD_OPER_EN, 16'h0000);
		rd(SER_CMD_RD_OPER_COND, 16'h0000);
		rd(SER_CMD_RD_OPER_EVT, 16'h0000);
		chk({15'h0000, sum.oper}, 16'h0000);
		i_host.query(ser_cmd_code_t'(4'hD), d, ok);
		chk({15'h0000, ok}, 16'h0000);
		// Enable low freezes everything: no reply, no latched error
		@(posedge i_ref_clk);
		i_ce <= 1'b0;
		fire(5'h01, 16'hFF90);
		chk({15'h0000, log_o.valid}, 16'h0000);
		i_host.query(SER_CMD_RD_ESR, d, ok);
		chk({15'h0000, ok}, 16'h0000);
		@(posedge i_ref_clk);
		i_ce <= 1'b1;
		rd(SER_CMD_RD_ESR, 16'h0000);
		test_done();
	end
endmodule
